// *** core/oag_core.sv ***
// Implementation choices: the APB slave port and the address map.
`timescale 1ns/10ps
// What this block does
// - Register mode returns register, no memory access
// - Registers selected by fixed five-bit machine codes
// - Direct address is page low byte over offset
// - Immediate operand is 16 or 24 bits
// - PC-relative target adds displacement to counter
// - Indirect arithmetic uses unsigned low 24 bits
// - Auxiliary update keeps upper eight bits
// - Auxiliary updates never stall the datapath
// - Five-bit mod field selects indirect variant
// - Displacement is eight-bit field or one
// - Index registers serve as 24-bit displacements
// - Auxiliary selector is binary index number
// - Codes 00000/00010: add, optional write-back
// - Codes 00001/00011: subtract, optional write-back
// - Codes 00100/00101: post add or subtract
// - Codes 00110/00111: post circular add or subtract
// - Circular step stays inside buffer boundary
// - Bit-reversed mode stores reversed-carry result
// - Code 11000 uses register unchanged
module oag_core (
    // Clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // APB register port
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [oag_pkg::PAW-1:0] paddr,
    input wire logic [oag_pkg::DW-1:0] pwdata,
    output logic [oag_pkg::DW-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // Request from the instruction decoder
    input wire logic req_valid,
    input wire oag_pkg::oag_mode_t req_mode,
    input wire logic [oag_pkg::DW-1:0] req_word,
    input wire logic req_long,
    input wire logic req_disp_one,
    input wire logic [oag_pkg::AW-1:0] req_pc,
    output logic req_ready,
    // Result toward the memory bus and datapath
    output logic rsp_valid,
    output logic rsp_mem,
    output logic [oag_pkg::AW-1:0] rsp_addr,
    output logic [oag_pkg::DW-1:0] rsp_data,
    output logic rsp_err
);
    import oag_pkg::*;

    typedef struct packed {
        logic [REG_COUNT-1:0][DW-1:0] regs;
        logic enable;
        logic valid;
        logic mem;
        logic [AW-1:0] addr;
        logic [DW-1:0] data;
        logic err;
        logic wrote;
        logic [DW-1:0] rdata;
        logic rd_ok;
    } oag_state_t;

    oag_state_t st_r;
    oag_state_t st_nxt;

    oag_aux_if aux ();

    oag_aux_unit u_aux (
        .a(aux.unit)
    );

    logic take;
    logic [2:0] aux_address_reg;
    logic [CODE_W-1:0] ar_code;
    logic [4:0] mod;
    logic [CODE_W-1:0] sel;
    logic [AW-1:0] small_disp;
    logic [AW-1:0] pc_disp;
    logic [IDX_W-1:0] bidx;
    logic bus_wr;
    logic bus_hit;
    logic reg_hit;
    logic [DW-1:0] rd_word;

    // Instruction field extraction
    assign mod = req_word[MOD_LSB +: 5];
    assign aux_address_reg = req_word[ARN_LSB +: 3];
    assign ar_code = CODE_AUX0 + {2'b00, aux_address_reg};
    assign sel = req_word[SEL_LSB +: CODE_W];

    // Displacement: explicit byte or implied one
    always_comb begin
        if (req_disp_one) begin
            small_disp = DISP_ONE;
        end else begin
            small_disp = {16'h0000, req_word[DISP_LSB +: DISP_W]};
        end
    end

    // Feed the auxiliary arithmetic unit
    always_comb begin
        aux.mod = mod;
        aux.ar = st_r.regs[ar_code][AW-1:0];
        aux.blk = st_r.regs[CODE_BLK][AW-1:0];
        aux.rdisp = st_r.regs[CODE_IDX0][AW-1:0];
        unique case (mod[4:3])
            GRP_IDX0: aux.disp = st_r.regs[CODE_IDX0][AW-1:0];
            GRP_IDX1: aux.disp = st_r.regs[CODE_IDX1][AW-1:0];
            GRP_DISP: aux.disp = small_disp;
            GRP_SPEC: aux.disp = small_disp;
        endcase
    end

    // PC-relative displacement, sign-extended
    always_comb begin
        if (req_long) begin
            pc_disp = req_word[AW-1:0];
        end else begin
            pc_disp = {{(AW-OFS_W){req_word[OFS_W-1]}}, req_word[OFS_W-1:0]};
        end
    end

    // APB decode
    assign bidx = paddr[PAW-1:2];
    assign reg_hit = (bidx < IDX_W'(REG_COUNT));
    assign bus_hit = reg_hit || (bidx == CTRL_IDX) || (bidx == STAT_IDX);
    assign bus_wr = ce && psel && penable && pwrite && reg_hit;
    assign pready = ce && (pwrite || st_r.rd_ok); // Reads wait for a captured word
    assign pslverr = psel && penable && (!bus_hit || (pwrite && bidx == STAT_IDX));

    // Word selected for reading, captured into the state
    always_comb begin
        rd_word = 32'h0000_0000;
        if (psel && reg_hit) begin
            rd_word = st_r.regs[bidx[CODE_W-1:0]];
        end else if (psel && bidx == CTRL_IDX) begin
            rd_word[CTRL_EN_BIT] = st_r.enable;
        end else if (psel && bidx == STAT_IDX) begin
            rd_word[AW-1:0] = st_r.addr;
            rd_word[STAT_ERR_BIT] = st_r.err;
            rd_word[STAT_WR_BIT] = st_r.wrote;
        end
    end

    // Requests taken every enabled cycle, no wait states
    assign req_ready = ce && st_r.enable;
    assign take = req_valid && req_ready;

    // Next-state logic
    always_comb begin
        st_nxt = st_r;
        st_nxt.valid = 1'b0;
        // Bus writes to the CPU register file
        for (int i = 0; i < REG_COUNT; i++) begin
            if (bus_wr && bidx == IDX_W'(i)) begin
                st_nxt.regs[i] = pwdata;
            end
        end
        if (ce && psel && penable && pwrite && bidx == CTRL_IDX) begin
            st_nxt.enable = pwdata[CTRL_EN_BIT];
        end
        // Read word taken once per transfer, freed when the transfer ends
        if (psel && penable && pready) begin
            st_nxt.rd_ok = 1'b0;
        end else if (psel && !st_r.rd_ok) begin
            st_nxt.rdata = rd_word;
            st_nxt.rd_ok = 1'b1;
        end
        if (take) begin
            st_nxt.valid = 1'b1;
            st_nxt.err = 1'b0;
            st_nxt.wrote = 1'b0;
            st_nxt.mem = 1'b0;
            st_nxt.addr = 24'h000000;
            st_nxt.data = 32'h0000_0000;
            unique case (req_mode)
                OAG_MODE_REG: begin
                    // Operand straight from the register file
                    if (sel <= CODE_LAST) begin
                        st_nxt.data = st_r.regs[sel];
                    end else begin
                        st_nxt.err = 1'b1;
                    end
                end
                OAG_MODE_DIRECT: begin
                    st_nxt.mem = 1'b1;
                    st_nxt.addr = {st_r.regs[CODE_PAGE][PAGE_W-1:0],
                                   req_word[OFS_W-1:0]};
                end
                OAG_MODE_IMM: begin
                    if (req_long) begin
                        st_nxt.data = {8'h00, req_word[AW-1:0]};
                    end else begin
                        st_nxt.data = {16'h0000, req_word[OFS_W-1:0]};
                    end
                end
                OAG_MODE_PCREL: begin
                    st_nxt.addr = req_pc + pc_disp;
                end
                OAG_MODE_INDIRECT: begin
                    if (aux.legal) begin
                        st_nxt.mem = 1'b1;
                        st_nxt.addr = aux.addr;
                        st_nxt.wrote = aux.ar_wr;
                        if (aux.ar_wr) begin
                            // Upper byte of the pointer left untouched
                            st_nxt.regs[ar_code] = {st_r.regs[ar_code][DW-1:AW],
                                                    aux.ar_new};
                        end
                    end else begin
                        st_nxt.err = 1'b1;
                    end
                end
                default: begin
                    st_nxt.err = 1'b1;
                end
            endcase
        end
        if (!ce) begin
            st_nxt = st_r;
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r.regs <= '0;
            st_r.enable <= CTRL_RESET[CTRL_EN_BIT];
            st_r.valid <= 1'b0;
            st_r.mem <= 1'b0;
            st_r.addr <= 24'h000000;
            st_r.data <= 32'h0000_0000;
            st_r.err <= 1'b0;
            st_r.wrote <= 1'b0;
            st_r.rdata <= 32'h0000_0000;
            st_r.rd_ok <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Result outputs from flip-flops
    assign rsp_valid = st_r.valid;
    assign rsp_mem = st_r.mem;
    assign rsp_addr = st_r.addr;
    assign rsp_data = st_r.data;
    assign rsp_err = st_r.err;
    assign prdata = st_r.rdata;
endmodule

// *** shared/oag_pkg.sv ***
package oag_pkg;
    // Sizes of the register file and address fields
    localparam int REG_COUNT = 28;
    localparam int AW = 24;
    localparam int DW = 32;
    localparam int PAW = 8;
    localparam int IDX_W = 6;
    localparam int CODE_W = 5;

    // Machine codes of the CPU registers, also their bus word index
    localparam logic [CODE_W-1:0] CODE_EXT0 = 5'h00;
    localparam logic [CODE_W-1:0] CODE_AUX0 = 5'h08;
    localparam logic [CODE_W-1:0] CODE_PAGE = 5'h10;
    localparam logic [CODE_W-1:0] CODE_IDX0 = 5'h11;
    localparam logic [CODE_W-1:0] CODE_IDX1 = 5'h12;
    localparam logic [CODE_W-1:0] CODE_BLK = 5'h13;
    localparam logic [CODE_W-1:0] CODE_SP = 5'h14;
    localparam logic [CODE_W-1:0] CODE_STAT = 5'h15;
    localparam logic [CODE_W-1:0] CODE_IEN = 5'h16;
    localparam logic [CODE_W-1:0] CODE_IFLG = 5'h17;
    localparam logic [CODE_W-1:0] CODE_IOF = 5'h18;
    localparam logic [CODE_W-1:0] CODE_RPT_S = 5'h19;
    localparam logic [CODE_W-1:0] CODE_RPT_E = 5'h1A;
    localparam logic [CODE_W-1:0] CODE_LAST = 5'h1B;

    // Block control and status words, bus word index
    localparam logic [IDX_W-1:0] CTRL_IDX = 6'h20;
    localparam logic [IDX_W-1:0] STAT_IDX = 6'h21;
    localparam int CTRL_EN_BIT = 0;
    localparam logic [DW-1:0] CTRL_RESET = 32'h0000_0001;
    localparam int STAT_ERR_BIT = 24;
    localparam int STAT_WR_BIT = 25;
    localparam logic [DW-1:0] REG_RESET = 32'h0000_0000;

    // Instruction word field positions
    localparam int MOD_LSB = 11;
    localparam int ARN_LSB = 8;
    localparam int DISP_LSB = 0;
    localparam int DISP_W = 8;
    localparam int SEL_LSB = 0;
    localparam int PAGE_W = 8;
    localparam int OFS_W = 16;

    // Modification field groups and special codes
    localparam logic [1:0] GRP_DISP = 2'h0;
    localparam logic [1:0] GRP_IDX0 = 2'h1;
    localparam logic [1:0] GRP_IDX1 = 2'h2;
    localparam logic [1:0] GRP_SPEC = 2'h3;
    localparam logic [4:0] MOD_PLAIN = 5'h18;
    localparam logic [4:0] MOD_BITREV = 5'h19;
    localparam logic [2:0] OP_PRE_ADD = 3'h0;
    localparam logic [2:0] OP_PRE_SUB = 3'h1;
    localparam logic [2:0] OP_PRE_ADD_WB = 3'h2;
    localparam logic [2:0] OP_PRE_SUB_WB = 3'h3;
    localparam logic [2:0] OP_POST_ADD = 3'h4;
    localparam logic [2:0] OP_POST_SUB = 3'h5;
    localparam logic [2:0] OP_CIRC_ADD = 3'h6;
    localparam logic [2:0] OP_CIRC_SUB = 3'h7;
    localparam logic [AW-1:0] DISP_ONE = 24'h000001;

    // Addressing mode requested by the decoder
    typedef enum logic [2:0] {
        OAG_MODE_REG,
        OAG_MODE_DIRECT,
        OAG_MODE_INDIRECT,
        OAG_MODE_IMM,
        OAG_MODE_PCREL
    } oag_mode_t;
endpackage

// *** shared/oag_aux_if.sv ***
`timescale 1ns/10ps
interface oag_aux_if;
    logic [4:0] mod;
    logic [23:0] ar;
    logic [23:0] disp;
    logic [23:0] rdisp;
    logic [23:0] blk;
    logic [23:0] addr;
    logic [23:0] ar_new;
    logic ar_wr;
    logic legal;

    modport core (output mod, ar, disp, rdisp, blk, input addr, ar_new, ar_wr, legal);
    modport unit (input mod, ar, disp, rdisp, blk, output addr, ar_new, ar_wr, legal);
endinterface

// *** core/oag_aux_unit.sv ***
`timescale 1ns/10ps
module oag_aux_unit (
    // Operands from and results to the core
    oag_aux_if.unit a
);
    import oag_pkg::*;

    // Wrap a stepped pointer inside a power-of-two aligned buffer
    function automatic logic [23:0] circ_step(input logic [23:0] ar, input logic [23:0] step,
                                              input logic [23:0] blk, input logic up);
        logic [23:0] mask;
        logic [23:0] idx;
        logic [23:0] nidx;
        mask = blk;
        mask = mask | (mask >> 1);
        mask = mask | (mask >> 2);
        mask = mask | (mask >> 4);
        mask = mask | (mask >> 8);
        mask = mask | (mask >> 16);
        idx = ar & mask;
        if (up) begin
            nidx = idx + step;
            if (nidx >= blk) begin
                nidx = nidx - blk;
            end
        end else if (idx >= step) begin
            nidx = idx - step;
        end else begin
            nidx = idx + blk - step;
        end
        if (blk == 24'h000000) begin
            circ_step = ar;
        end else begin
            circ_step = (ar & ~mask) | (nidx & mask);
        end
    endfunction

    // Mirror the bit order of a 24-bit field
    function automatic logic [23:0] mirror(input logic [23:0] v);
        for (int i = 0; i < AW; i++) begin
            mirror[i] = v[AW-1-i];
        end
    endfunction

    logic [23:0] sum;
    logic [23:0] dif;

    // Unsigned 24-bit pre and post arithmetic
    assign sum = a.ar + a.disp;
    assign dif = a.ar - a.disp;

    // Mod field decode
    always_comb begin
        a.addr = a.ar;
        a.ar_new = a.ar;
        a.ar_wr = 1'b0;
        a.legal = 1'b1;
        if (a.mod[4:3] != GRP_SPEC) begin
            unique case (a.mod[2:0])
                OP_PRE_ADD: a.addr = sum;
                OP_PRE_SUB: a.addr = dif;
                OP_PRE_ADD_WB: begin
                    a.addr = sum;
                    a.ar_new = sum;
                    a.ar_wr = 1'b1;
                end
                OP_PRE_SUB_WB: begin
                    a.addr = dif;
                    a.ar_new = dif;
                    a.ar_wr = 1'b1;
                end
                OP_POST_ADD: begin
                    a.ar_new = sum;
                    a.ar_wr = 1'b1;
                end
                OP_POST_SUB: begin
                    a.ar_new = dif;
                    a.ar_wr = 1'b1;
                end
                OP_CIRC_ADD: begin
                    a.ar_new = circ_step(a.ar, a.disp, a.blk, 1'b1);
                    a.ar_wr = 1'b1;
                end
                OP_CIRC_SUB: begin
                    a.ar_new = circ_step(a.ar, a.disp, a.blk, 1'b0);
                    a.ar_wr = 1'b1;
                end
            endcase
        end else if (a.mod == MOD_PLAIN) begin
            a.addr = a.ar;
        end else if (a.mod == MOD_BITREV) begin
            // Reverse-carry add of the first index register
            a.ar_new = mirror(mirror(a.ar) + mirror(a.rdisp));
            a.ar_wr = 1'b1;
        end else begin
            a.legal = 1'b0;
        end
    end
endmodule

// *** tb/oag_mem_model.sv ***
`timescale 1ns/10ps
module oag_mem_model (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Address side of the core
    input wire logic rsp_valid,
    input wire logic rsp_mem,
    input wire logic [oag_pkg::AW-1:0] rsp_addr,
    // Last fetch seen and fetch count
    output logic [oag_pkg::AW-1:0] last_addr,
    output int hits
);
    import oag_pkg::*;
    // Record each data fetch the core launches
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_addr <= '0;
            hits <= 0;
        end else if (rsp_valid && rsp_mem) begin
            last_addr <= rsp_addr;
            hits <= hits + 1;
        end
    end
endmodule

// *** tb/oag_chk.sv ***
`timescale 1ns/10ps
module oag_chk (
    // Clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // APB handshake
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    // Decoder request
    input wire logic req_valid,
    input wire oag_pkg::oag_mode_t req_mode,
    input wire logic [oag_pkg::DW-1:0] req_word,
    input wire logic req_long,
    input wire logic [oag_pkg::AW-1:0] req_pc,
    input wire logic req_ready,
    // Result
    input wire logic rsp_valid,
    input wire logic rsp_mem,
    input wire logic [oag_pkg::AW-1:0] rsp_addr,
    input wire logic [oag_pkg::DW-1:0] rsp_data,
    input wire logic rsp_err
);
    import oag_pkg::*;
    logic tk;
    // Request taken at this edge
    assign tk = req_valid && req_ready;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // Answer timing and holding
    resp_pulse_a: assert property (tk |=> rsp_valid) else $error("no answer");
    idle_hold_a: assert property (ce && !tk |=> !rsp_valid && $stable(rsp_addr))
        else $error("answer without request");
    ready_gate_a: assert property (!ce |-> !req_ready && !pready) else $error("ready");
    // Mode results
    reg_nomem_a: assert property (tk && req_mode == OAG_MODE_REG |=> !rsp_mem)
        else $error("register mode touched memory");
    reg_code_a: assert property (tk && req_mode == OAG_MODE_REG |=>
        rsp_err == ($past(req_word[4:0]) > 5'h1B)) else $error("register code check");
    direct_low_a: assert property (tk && req_mode == OAG_MODE_DIRECT |=>
        rsp_mem && rsp_addr[15:0] == $past(req_word[15:0])) else $error("direct offset");
    imm_short_a: assert property (tk && req_mode == OAG_MODE_IMM && !req_long |=>
        rsp_data == {16'h0000, $past(req_word[15:0])}) else $error("short immediate");
    pc_long_a: assert property (tk && req_mode == OAG_MODE_PCREL && req_long |=>
        rsp_addr == $past(req_pc) + $past(req_word[23:0])) else $error("long pc target");
    ind_mem_a: assert property (tk && req_mode == OAG_MODE_INDIRECT &&
        req_word[15:11] <= 5'h19 |=> rsp_mem && !rsp_err) else $error("indirect fetch");
    mod_bad_a: assert property (tk && req_mode == OAG_MODE_INDIRECT &&
        req_word[15:11] > 5'h19 |=> rsp_err) else $error("illegal mod accepted");
    // Main scenarios
    cov_ind: cover property (tk && req_mode == OAG_MODE_INDIRECT);
    cov_dir: cover property (tk && req_mode == OAG_MODE_DIRECT);
    cov_slverr: cover property (psel && penable && pslverr);
endmodule
bind oag_core oag_chk u_oag_chk (.*);

// *** tb/operand_address_generator_tb_top.sv ***
`timescale 1ns/10ps
module operand_address_generator_tb_top;
    import oag_pkg::*;
    logic pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = '0;
    logic [31:0] pwdata = '0, req_word = '0, prdata, rsp_data, r, w, ar, pg;
    logic pready, pslverr, req_ready, rsp_valid, rsp_mem, rsp_err, e, one;
    logic req_valid = 0, req_long = 0, req_disp_one = 0;
    oag_mode_t req_mode = OAG_MODE_REG;
    logic [23:0] req_pc = '0, rsp_addr, last_addr, bk, pc, i0, i1, dsp;
    logic [7:0] d;
    logic [4:0] code;
    logic [47:0] x;
    int hits, i, md, n, seed;
    int n_errors = 0;
    int check_count = 0;
    // Core clock
    always #4 pclk = ~pclk;
    oag_core u_oag_core (.*);
    oag_mem_model u_oag_mem_model (.*);
    // Verdict
    task automatic tally_and_finish();
        $display("errors %0d checks %0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // One APB transfer, held until pready
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] dt);
        int k;
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= dt;
        @(posedge pclk);
        penable <= 1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        r = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
        if (k == 50) begin
            n_errors++;
            tally_and_finish();
        end
    endtask
    // One decoder request, answer looked at after the taking edge
    task automatic rq(input oag_mode_t m, input logic [31:0] wd, input logic lg,
                      input logic o, input logic [23:0] p);
        int k;
        @(posedge pclk);
        req_mode <= m;
        req_word <= wd;
        req_long <= lg;
        req_disp_one <= o;
        req_pc <= p;
        req_valid <= 1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (req_ready !== 1'b1 && k < 50);
        req_valid <= 0;
        if (k == 50) begin
            n_errors++;
            tally_and_finish();
        end
        #1;
        chk(rsp_valid, 1);
    endtask
    // Bit order of a 24-bit field mirrored
    function automatic logic [23:0] rev(input logic [23:0] v);
        for (int j = 0; j < 24; j++) begin
            rev[j] = v[23 - j];
        end
    endfunction
    // Expected {address, new register} of an indirect access
    function automatic logic [47:0] ind_exp(input logic [4:0] c, input logic [23:0] a,
                                            input logic [23:0] dd, input logic [23:0] b,
                                            input logic [23:0] r0);
        logic [23:0] m, xi, nw;
        m = b | (b >> 1);
        m = m | (m >> 2);
        m = m | (m >> 4);
        m = m | (m >> 8);
        m = m | (m >> 16);
        xi = a & m;
        if (c == 5'h19) begin
            return {a, rev(rev(a) + rev(r0))};
        end
        case ((c[4:3] == 2'h3) ? 5'h1F : {2'b00, c[2:0]})
            5'h00: return {a + dd, a};
            5'h01: return {a - dd, a};
            5'h02: return {a + dd, a + dd};
            5'h03: return {a - dd, a - dd};
            5'h04: return {a, a + dd};
            5'h05: return {a, a - dd};
            5'h06: nw = (xi + dd >= b) ? xi + dd - b : xi + dd;
            5'h07: nw = (xi < dd) ? xi + b - dd : xi - dd;
            default: return {a, a};
        endcase
        return {a, (a & ~m) | nw};
    endfunction
    initial begin
        seed = $urandom(32'hDD002612);
        repeat (20) @(posedge pclk);
        presetn <= 1;
        // Reset value, refused accesses
        apb(0, 8'h80, 0);
        chk(r, CTRL_RESET);
        apb(1, 8'h84, 32'hFFFF_FFFF);
        chk(e, 1);
        apb(0, 8'h88, 0);
        chk(e, 1);
        // Every register code, then one past the last
        for (i = 0; i < 28; i++) begin
            w = $urandom();
            apb(1, 8'(i * 4), w);
            rq(OAG_MODE_REG, i, 0, 0, 0);
            chk(rsp_data, w);
            chk({rsp_mem, rsp_err}, 0);
        end
        rq(OAG_MODE_REG, 32'h1C, 0, 0, 0);
        chk(rsp_err, 1);
        chk(hits, 0);
        // Direct, immediate and pc-relative, both widths
        for (i = 0; i < 4; i++) begin
            pg = $urandom();
            w = $urandom();
            pc = 24'($urandom());
            apb(1, 8'h40, pg);
            rq(OAG_MODE_DIRECT, w, 0, 0, 0);
            chk(rsp_addr, {pg[7:0], w[15:0]});
            rq(OAG_MODE_IMM, w, i[0], 0, 0);
            chk(rsp_data, i[0] ? {8'h00, w[23:0]} : {16'h0000, w[15:0]});
            rq(OAG_MODE_PCREL, w, i[0], 0, pc);
            chk(rsp_addr, 24'(pc + (i[0] ? w[23:0] : {{8{w[15]}}, w[15:0]})));
        end
        // Every mod code the unit decodes, index registers with a random top byte
        for (md = 0; md < 26; md++) begin
            repeat (3) begin
                n = $urandom_range(7);
                bk = 24'($urandom_range(208, 9));
                ar = ($urandom() & 32'hFFFF_FF00) | ($urandom() % bk);
                d = 8'($urandom() % bk);
                one = 1'($urandom());
                i0 = 24'($urandom() % bk);
                i1 = 24'($urandom() % bk);
                code = (md < 24) ? 5'(md) : ((md == 24) ? MOD_PLAIN : MOD_BITREV);
                apb(1, 8'h4C, {8'($urandom()), bk});
                apb(1, 8'h44, {8'($urandom()), i0});
                apb(1, 8'h48, {8'($urandom()), i1});
                apb(1, 8'(32 + n * 4), ar);
                rq(OAG_MODE_INDIRECT, {16'h0000, code, 3'(n), d}, 0, one, 0);
                dsp = one ? DISP_ONE : {16'h0000, d};
                dsp = (code[4:3] == 2'h1) ? i0 : ((code[4:3] == 2'h2) ? i1 : dsp);
                x = ind_exp(code, ar[23:0], dsp, bk, i0);
                chk(rsp_addr, x[47:24]);
                apb(0, 8'(32 + n * 4), 0);
                chk(r, {ar[31:24], x[23:0]});
                chk(last_addr, x[47:24]);
            end
        end
        // Illegal mod code and its status word, then a disabled and a frozen core
        rq(OAG_MODE_INDIRECT, 32'h0000_D000, 0, 0, 0);
        chk(rsp_err, 1);
        apb(0, 8'h84, 0);
        chk(r, 32'h1 << STAT_ERR_BIT);
        apb(1, 8'h80, 0);
        @(posedge pclk);
        chk(req_ready, 0);
        apb(1, 8'h80, CTRL_RESET);
        @(posedge pclk);
        ce <= 0;
        repeat (3) @(posedge pclk);
        chk({req_ready, pready}, 0);
        ce <= 1;
        tally_and_finish();
    end
endmodule
